// file: verilog/ecp_pkg.sv
// ecp_pkg: constants for the external control port block
// assumes a single 25 MHz clock and an axi4-lite register slave
package ecp_pkg;

   // clock and time bases
   localparam int unsigned CLK_NS     = 40;
   localparam int unsigned TICK_NS    = 100000;   // trigger width unit, 0.1 ms
   localparam int unsigned TICK_CYC   = TICK_NS / CLK_NS;
   localparam int unsigned FILT_NS    = 40000;    // input filter time, 40 us
   localparam int unsigned FILT_CYC   = (FILT_NS + CLK_NS - 1) / CLK_NS;

   // register byte offsets
   localparam logic [3:0] OFS_CTRL    = 4'h0;
   localparam logic [3:0] OFS_TRIGW   = 4'h4;
   localparam logic [3:0] OFS_STAT    = 4'h8;

   // control register field positions
   localparam int unsigned CTRL_MODE_LSB = 0;    // 2 bits
   localparam int unsigned CTRL_POL_LSB  = 8;    // 2 bits
   localparam int unsigned CTRL_TNEG_BIT = 16;

   // reset values
   localparam logic [1:0]  MODE_RST   = 2'h1;
   localparam logic [1:0]  POL_RST    = 2'h2;
   localparam logic        TNEG_RST   = 1'b0;
   localparam logic [15:0] TRIGW_RST  = 16'h0064; // 100 units, 10.0 ms

   // external control selector codes
   localparam logic [1:0] MODE_DISABLE = 2'h1;
   localparam logic [1:0] MODE_ENABLE  = 2'h2;
   localparam logic [1:0] MODE_COMPAN  = 2'h3;

   // status polarity codes
   localparam logic [1:0] POL_NEG = 2'h1;
   localparam logic [1:0] POL_POS = 2'h2;

   // active function codes
   localparam logic [1:0] FUNC_CONT = 2'h0;
   localparam logic [1:0] FUNC_SEQ  = 2'h1;
   localparam logic [1:0] FUNC_SIM  = 2'h2;

   // command input indices
   localparam int unsigned IN_OFF    = 0;
   localparam int unsigned IN_ON     = 1;
   localparam int unsigned IN_START  = 2;
   localparam int unsigned IN_STOP   = 3;
   localparam int unsigned IN_HOLD   = 4;
   localparam int unsigned IN_BR1    = 5;
   localparam int unsigned IN_BR2    = 6;
   localparam int unsigned IN_RECALL = 7;
   localparam int unsigned IN_MEM1   = 8;
   localparam int unsigned IN_MEM2   = 9;
   localparam int unsigned IN_PEAK   = 10;
   localparam int unsigned IN_NUM    = 11;

   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // trigger pulse states
   typedef enum logic [1:0] {
      TRG_IDLE  = 2'b01,
      TRG_PULSE = 2'b10
   } ecp_trg_t;

endpackage : ecp_pkg

// file: verilog/ecp_in_cond.sv
// ecp_in_cond: one command pin, synchronised, filtered, falling edge found
// assumes the pin idles high (pull-up) and is asynchronous to aclk
`timescale 1ns/1ps
module ecp_in_cond #(
   parameter int unsigned FILT = 1000
) (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // pin and results
   input  wire logic pin_i,
   output logic      level_o,
   output logic      fall_o
);
   logic                     s1_q;
   logic                     s2_q;
   logic [$clog2(FILT+1)-1:0] cnt_q;

   // two-stage synchroniser, first stage read only by second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
      end
   end

   // level accepted only after FILT stable cycles
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q   <= '0;
         level_o <= 1'b1;
         fall_o  <= 1'b0;
      end else begin
         fall_o <= 1'b0;
         if (s2_q == level_o) begin
            cnt_q <= '0;
         end else if (cnt_q == ($clog2(FILT+1))'(FILT - 1)) begin
            cnt_q   <= '0;
            level_o <= s2_q;
            fall_o  <= ~s2_q;   // one pulse per accepted falling edge, none on a rising edge
         end else begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

endmodule : ecp_in_cond

// file: verilog/ecp_port.sv
// ecp_port: external control port, command inputs and status outputs
// assumes internal status and requests on aclk, pins asynchronous
//
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module ecp_port #(
   parameter int unsigned FILT_CYC = ecp_pkg::FILT_CYC,
   parameter int unsigned TICK_CYC = ecp_pkg::TICK_CYC
) (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data and response
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // command pins, idle high, active falling edge; memory select pins read as levels
   input  wire logic        pin_out_off_i,
   input  wire logic        pin_out_on_i,
   input  wire logic        pin_seq_start_i,
   input  wire logic        pin_seq_stop_i,
   input  wire logic        pin_seq_hold_i,
   input  wire logic        pin_branch1_i,
   input  wire logic        pin_branch2_i,
   input  wire logic        pin_recall_i,
   input  wire logic        pin_mem_sel1_i,
   input  wire logic        pin_mem_sel2_i,
   input  wire logic        pin_peak_clear_i,
   // internal state feeding status pins, command gating and recall
   input  wire logic        power_on_i,
   input  wire logic        out_on_i,
   input  wire logic        prot_active_i,
   input  wire logic        limiter_active_i,
   input  wire logic        gain_regulation_state_i,
   input  wire logic        busy_i,
   input  wire logic        range_100v_i,
   input  wire logic [1:0]  step_code_i,
   input  wire logic        trig_req_i,
   input  wire logic        remote_active_i,
   input  wire logic [1:0]  active_func_i,
   // status pins
   output logic             pin_power_o,
   output logic             pin_out_state_o,
   output logic             pin_prot_o,
   output logic             pin_limiter_o,
   output logic             pin_gain_reg_o,
   output logic             pin_busy_o,
   output logic             pin_range_o,
   output logic             pin_step0_o,
   output logic             pin_step1_o,
   output logic             pin_trigger_o,
   // command pulses and recall codes to internal logic
   output logic             cmd_out_off_o,
   output logic             cmd_out_on_o,
   output logic             cmd_seq_start_o,
   output logic             cmd_seq_stop_o,
   output logic             cmd_seq_hold_o,
   output logic             cmd_branch1_o,
   output logic             cmd_branch2_o,
   output logic             cmd_peak_clear_o,
   output logic             cmd_recall_o,
   output logic             cmd_compile_o,
   output logic [1:0]       recall_mem_o,
   output logic [1:0]       recall_func_o,
   // companion device control enable
   output logic             companion_control_mode_o
);
   localparam int unsigned N = ecp_pkg::IN_NUM;

   logic [N-1:0]  pins;
   logic [N-1:0]  lvl;
   logic [N-1:0]  fall;
   logic [1:0]    mode_q;
   logic [1:0]    pol_q;
   logic          tneg_q;
   logic [15:0]   trigw_q;
   logic          gate;
   logic          neg;
   logic          aw_full_q;
   logic          w_full_q;
   logic [3:0]    awaddr_q;
   logic [31:0]   wdata_q;
   logic [3:0]    wstrb_q;
   logic          wr_do;
   logic [31:0]   stat;
   logic [$clog2(TICK_CYC)-1:0] div_q;
   logic          tick;
   ecp_pkg::ecp_trg_t trg_q;
   logic [15:0]   tcnt_q;

   // gather pins for the conditioners
   assign pins = {pin_peak_clear_i, pin_mem_sel2_i, pin_mem_sel1_i, pin_recall_i,
                  pin_branch2_i, pin_branch1_i, pin_seq_hold_i, pin_seq_stop_i,
                  pin_seq_start_i, pin_out_on_i, pin_out_off_i};

   // one conditioner per pin, logic and contact inputs alike
   for (genvar i = 0; i < N; i++) begin : g_in
      ecp_in_cond #(.FILT(FILT_CYC)) u_cond (
         .aclk    (aclk),
         .aresetn (aresetn),
         .pin_i   (pins[i]),
         .level_o (lvl[i]),
         .fall_o  (fall[i])
      );
   end

   // commands pass only when enabled and not under remote control
   assign gate = (mode_q == ecp_pkg::MODE_ENABLE) && !remote_active_i;
   assign neg  = (pol_q == ecp_pkg::POL_NEG);

   // companion control only in its own setting
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         companion_control_mode_o <= 1'b0;
      end else begin
         companion_control_mode_o <= (mode_q == ecp_pkg::MODE_COMPAN);
      end
   end

   // gated command pulses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_out_off_o    <= 1'b0;
         cmd_out_on_o     <= 1'b0;
         cmd_seq_start_o  <= 1'b0;
         cmd_seq_stop_o   <= 1'b0;
         cmd_seq_hold_o   <= 1'b0;
         cmd_branch1_o    <= 1'b0;
         cmd_branch2_o    <= 1'b0;
         cmd_peak_clear_o <= 1'b0;
      end else begin
         cmd_out_off_o    <= gate & fall[ecp_pkg::IN_OFF];
         cmd_out_on_o     <= gate & fall[ecp_pkg::IN_ON];
         cmd_seq_start_o  <= gate & fall[ecp_pkg::IN_START];
         cmd_seq_stop_o   <= gate & fall[ecp_pkg::IN_STOP];
         cmd_seq_hold_o   <= gate & fall[ecp_pkg::IN_HOLD];
         cmd_branch1_o    <= gate & fall[ecp_pkg::IN_BR1];
         cmd_branch2_o    <= gate & fall[ecp_pkg::IN_BR2];
         cmd_peak_clear_o <= gate & fall[ecp_pkg::IN_PEAK];
      end
   end

   // memory recall, memory code and function latched with the pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_recall_o  <= 1'b0;
         cmd_compile_o <= 1'b0;
         recall_mem_o  <= 2'h0;
         recall_func_o <= ecp_pkg::FUNC_CONT;
      end else begin
         cmd_recall_o  <= gate & fall[ecp_pkg::IN_RECALL];
         // compile follows a sequence or simulation load one cycle later
         cmd_compile_o <= cmd_recall_o && (recall_func_o == ecp_pkg::FUNC_SEQ ||
                          recall_func_o == ecp_pkg::FUNC_SIM);
         if (gate && fall[ecp_pkg::IN_RECALL]) begin
            recall_mem_o  <= {lvl[ecp_pkg::IN_MEM2], lvl[ecp_pkg::IN_MEM1]};
            recall_func_o <= active_func_i;
         end
      end
   end

   // status pins, driven in every selector setting
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_power_o     <= 1'b0;
         pin_out_state_o <= 1'b0;
         pin_prot_o      <= 1'b0;
         pin_limiter_o   <= 1'b0;
         pin_gain_reg_o  <= 1'b0;
         pin_busy_o      <= 1'b0;
         pin_range_o     <= 1'b0;
         pin_step0_o     <= 1'b0;
         pin_step1_o     <= 1'b0;
      end else begin
         pin_power_o     <= power_on_i;
         pin_out_state_o <= out_on_i ^ neg;
         pin_gain_reg_o  <= gain_regulation_state_i ^ neg;
         pin_prot_o      <= prot_active_i ^ neg;
         pin_limiter_o   <= limiter_active_i ^ neg;
         pin_busy_o      <= busy_i ^ neg;
         pin_range_o     <= range_100v_i;
         pin_step0_o     <= step_code_i[0];
         pin_step1_o     <= step_code_i[1];
      end
   end

   // 0.1 ms tick for trigger width
   always_ff @(posedge aclk) begin
      if (!aresetn || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end
   assign tick = (div_q == ($clog2(TICK_CYC))'(TICK_CYC - 1));

   // trigger pulse of programmed width and polarity
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trg_q  <= ecp_pkg::TRG_IDLE;
         tcnt_q <= 16'h0000;
      end else begin
         unique case (trg_q)
            ecp_pkg::TRG_IDLE: begin
               if (trig_req_i && trigw_q != 16'h0000) begin
                  trg_q  <= ecp_pkg::TRG_PULSE;
                  tcnt_q <= trigw_q;
               end
            end
            ecp_pkg::TRG_PULSE: begin
               if (tick) begin
                  tcnt_q <= tcnt_q - 1'b1;
                  if (tcnt_q == 16'h0001) begin
                     trg_q <= ecp_pkg::TRG_IDLE;
                  end
               end
            end
            default: trg_q <= ecp_pkg::TRG_IDLE;
         endcase
      end
   end

   // trigger pin level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_trigger_o <= 1'b0;
      end else begin
         pin_trigger_o <= (trg_q == ecp_pkg::TRG_PULSE) ^ tneg_q;
      end
   end

   // axi write channels taken in either order
   assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
   assign wr_do         = aw_full_q && w_full_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         awaddr_q  <= 4'h0;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end else if (wr_do) begin
            aw_full_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end else if (wr_do) begin
            w_full_q <= 1'b0;
         end
      end
   end

   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= ecp_pkg::RESP_OKAY;
      end else if (wr_do) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awaddr_q[3:2] == ecp_pkg::OFS_CTRL[3:2] ||
                          awaddr_q[3:2] == ecp_pkg::OFS_TRIGW[3:2]) ?
                         ecp_pkg::RESP_OKAY : ecp_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // control register, illegal selector and polarity codes ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_q  <= ecp_pkg::MODE_RST;
         pol_q   <= ecp_pkg::POL_RST;
         tneg_q  <= ecp_pkg::TNEG_RST;
         trigw_q <= ecp_pkg::TRIGW_RST;
      end else if (wr_do) begin
         if (awaddr_q[3:2] == ecp_pkg::OFS_CTRL[3:2]) begin
            if (wstrb_q[0] && wdata_q[ecp_pkg::CTRL_MODE_LSB +: 2] != 2'h0) begin
               mode_q <= wdata_q[ecp_pkg::CTRL_MODE_LSB +: 2];
            end
            if (wstrb_q[1] && (wdata_q[ecp_pkg::CTRL_POL_LSB +: 2] == ecp_pkg::POL_NEG ||
                wdata_q[ecp_pkg::CTRL_POL_LSB +: 2] == ecp_pkg::POL_POS)) begin
               pol_q <= wdata_q[ecp_pkg::CTRL_POL_LSB +: 2];
            end
            if (wstrb_q[2]) begin
               tneg_q <= wdata_q[ecp_pkg::CTRL_TNEG_BIT];
            end
         end else if (awaddr_q[3:2] == ecp_pkg::OFS_TRIGW[3:2]) begin
            if (wstrb_q[0]) begin
               trigw_q[7:0] <= wdata_q[7:0];
            end
            if (wstrb_q[1]) begin
               trigw_q[15:8] <= wdata_q[15:8];
            end
         end
      end
   end

   // status word: filtered pins, last recall, live state
   assign stat = {14'h0000, companion_control_mode_o, trg_q == ecp_pkg::TRG_PULSE,
                  step_code_i, remote_active_i, recall_mem_o, lvl};

   // axi read, one cycle after address taken
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= ecp_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= ecp_pkg::RESP_OKAY;
         unique case (s_axi_araddr[3:2])
            ecp_pkg::OFS_CTRL[3:2]:
               s_axi_rdata <= {15'h0000, tneg_q, 6'h00, pol_q, 6'h00, mode_q};
            ecp_pkg::OFS_TRIGW[3:2]:
               s_axi_rdata <= {16'h0000, trigw_q};
            ecp_pkg::OFS_STAT[3:2]:
               s_axi_rdata <= stat;
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= ecp_pkg::RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // checks on command gating, status pin levels and trigger start
   a_disabled_no_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(mode_q) == ecp_pkg::MODE_DISABLE |-> !cmd_out_on_o && !cmd_recall_o)
      else $error("command passed while disabled");
   a_remote_no_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(remote_active_i) |-> !cmd_out_off_o && !cmd_seq_start_o)
      else $error("command passed under remote control");
   a_companion_excl: assert property (@(posedge aclk) disable iff (!aresetn)
      companion_control_mode_o |=> !cmd_seq_stop_o && !cmd_peak_clear_o)
      else $error("port active with companion control");
   a_edge_to_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
      gate && fall[ecp_pkg::IN_ON] |=> cmd_out_on_o ##1 !cmd_out_on_o)
      else $error("output on command not one pulse");
   a_hold_to_cmd: assert property (@(posedge aclk) disable iff (!aresetn)
      cmd_seq_hold_o |-> $past(fall[ecp_pkg::IN_HOLD]) && $past(gate))
      else $error("hold command without edge");
   a_compile_follow: assert property (@(posedge aclk) disable iff (!aresetn)
      cmd_recall_o && recall_func_o != ecp_pkg::FUNC_CONT
      && recall_func_o != 2'h3 |=> cmd_compile_o)
      else $error("compile missing after recall");
   a_recall_mem_code: assert property (@(posedge aclk) disable iff (!aresetn)
      cmd_recall_o |-> recall_mem_o == $past({lvl[ecp_pkg::IN_MEM2], lvl[ecp_pkg::IN_MEM1]}))
      else $error("recall memory code wrong");
   a_outstate_pol: assert property (@(posedge aclk) disable iff (!aresetn)
      pin_out_state_o == ($past(out_on_i) ^ ($past(pol_q) == ecp_pkg::POL_NEG)))
      else $error("output state polarity wrong");
   a_prot_pol: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(pol_q) == ecp_pkg::POL_POS |-> pin_prot_o == $past(prot_active_i))
      else $error("protection polarity wrong");
   a_busy_pol: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(pol_q) == ecp_pkg::POL_NEG |-> pin_busy_o != $past(busy_i))
      else $error("busy polarity wrong");
   a_range_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
      pin_range_o == $past(range_100v_i) && pin_power_o == $past(power_on_i))
      else $error("fixed polarity output wrong");
   a_step_code: assert property (@(posedge aclk) disable iff (!aresetn)
      {pin_step1_o, pin_step0_o} == $past(step_code_i))
      else $error("step code wrong");
   a_trig_start: assert property (@(posedge aclk) disable iff (!aresetn)
      trg_q == ecp_pkg::TRG_IDLE && trig_req_i && trigw_q != 16'h0000
      |=> ##1 pin_trigger_o != tneg_q)
      else $error("trigger pulse not started");

endmodule : ecp_port

// file: sim/ecp_ctl_model.sv
// ecp_ctl_model: contact closures toward the command pins
// assumes pull-ups, so an open contact reads high
`timescale 1ns/1ps
module ecp_ctl_model (
   // closures and memory code
   input  wire logic [10:0] close_mask,
   input  wire logic [1:0]  mem,
   // pins
   output logic [10:0]      pins
);
   // closed contact pulls low, select lines carry the code
   assign pins = {~close_mask[10], mem, ~close_mask[7:0]};
endmodule : ecp_ctl_model

// file: sim/ecp_port_test.sv
// ecp_port_test: self-checking bench for ecp_port
// assumes short filter and tick counts; pins come from ecp_ctl_model
`timescale 1ns/1ps
module ecp_port_test;
   // signals named as the ports
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, clr;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdt;
   logic [1:0] s_axi_bresp, s_axi_rresp, step_code_i, active_func_i, recall_mem_o, mem;
   logic [1:0] recall_func_o, rsp;
   logic trig_req_i, remote_active_i, pin_power_o, pin_out_state_o, pin_prot_o, pin_limiter_o;
   logic pin_gain_reg_o, pin_busy_o, pin_range_o, pin_step0_o, pin_step1_o, pin_trigger_o;
   logic companion_control_mode_o;
   logic [10:0] close_mask, pins;
   logic [9:0] seen;
   wire [9:0] cmds;
   logic [6:0] st;
   int miscompares, comparisons, n;
   wire [4:0] flg = {pin_out_state_o, pin_prot_o, pin_limiter_o, pin_gain_reg_o, pin_busy_o};
   // pins from the model, status from st, pulses into cmds
   ecp_port #(.FILT_CYC(4), .TICK_CYC(5)) i_ecp_port (.*, .pin_out_off_i(pins[0]),
      .pin_out_on_i(pins[1]), .pin_seq_start_i(pins[2]), .pin_seq_stop_i(pins[3]),
      .pin_seq_hold_i(pins[4]), .pin_branch1_i(pins[5]), .pin_branch2_i(pins[6]),
      .pin_recall_i(pins[7]), .pin_mem_sel1_i(pins[8]), .pin_mem_sel2_i(pins[9]),
      .pin_peak_clear_i(pins[10]), .power_on_i(st[6]), .out_on_i(st[5]),
      .prot_active_i(st[4]), .limiter_active_i(st[3]), .gain_regulation_state_i(st[2]),
      .busy_i(st[1]), .range_100v_i(st[0]), .cmd_out_off_o(cmds[0]), .cmd_out_on_o(cmds[1]),
      .cmd_seq_start_o(cmds[2]), .cmd_seq_stop_o(cmds[3]), .cmd_seq_hold_o(cmds[4]),
      .cmd_branch1_o(cmds[5]), .cmd_branch2_o(cmds[6]), .cmd_recall_o(cmds[7]),
      .cmd_peak_clear_o(cmds[8]), .cmd_compile_o(cmds[9]));
   ecp_ctl_model i_ecp_ctl_model (.close_mask, .mem, .pins);
   // 40 ns clock
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   // pulses and their count since the last clear
   always @(posedge aclk) begin
      seen <= clr ? 10'h000 : seen | cmds;
      n <= clr ? 0 : n + $countones(cmds);
   end
   task automatic chk(input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test;
      if (miscompares == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test
   // bus write, both channels offered together
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [1:0] p;
      p = 2'h3;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (p != 2'h0) begin
         @(posedge aclk);
         p = p & ~{s_axi_wready, s_axi_awready};
         {s_axi_wvalid, s_axi_awvalid} <= p;
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      rsp = s_axi_bresp;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge aclk); // an edge between reads, so rready is never set twice in a step
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      rdt = s_axi_rdata;
      rsp = s_axi_rresp;
   endtask : rd
   // close one contact past the filter time, open it, judge pulses
   task automatic press(input int i, input logic [9:0] e);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      close_mask <= 11'h001 << i;
      repeat (12) @(posedge aclk);
      close_mask <= 11'h000;
      repeat (12) @(posedge aclk);
      chk(seen, e);
      chk(n, $countones(e));
   endtask : press
   task automatic t_regs;
      wr(4'hC, 32'h0000_0002);
      chk(rsp, 2'h2);
      rd(4'hC);
      chk(rsp, 2'h2);
      chk(rdt, 32'h0000_0000);
      rd(4'h0);
      chk(rdt, 32'h0000_0201);
      chk(rsp, 2'h0);
      rd(4'h4);
      chk(rdt, 32'h0000_0064);
   endtask : t_regs
   task automatic t_disabled;
      st <= 7'h7F;
      step_code_i <= 2'h2;
      press(0, 10'h000);
      chk({flg, pin_power_o, pin_range_o, pin_step1_o, pin_step0_o}, 9'h1FE);
      rd(4'h8);
      chk(rdt, 32'h0000_84FF);
   endtask : t_disabled
   task automatic t_enabled;
      wr(4'h0, 32'h0000_0202);
      for (int i = 0; i < 7; i++) press(i, 10'h001 << i);
      press(10, 10'h100);
   endtask : t_enabled
   task automatic t_recall;
      for (int m = 0; m < 4; m++) begin
         mem <= m[1:0];
         active_func_i <= 2'(m % 3);
         repeat (8) @(posedge aclk);
         press(7, (m % 3 != 0) ? 10'h280 : 10'h080);
         chk({recall_func_o, recall_mem_o}, {2'(m % 3), m[1:0]});
      end
   endtask : t_recall
   task automatic t_blocked;
      remote_active_i <= 1'b1;
      press(1, 10'h000);
      remote_active_i <= 1'b0;
      wr(4'h0, 32'h0000_0203);
      press(1, 10'h000);
      chk(companion_control_mode_o, 1'b1);
   endtask : t_blocked
   task automatic t_polarity;
      wr(4'h0, 32'h0000_0102);
      for (int v = 0; v < 2; v++) begin
         st <= {7{v[0]}};
         repeat (2) @(posedge aclk);
         chk(flg, {5{~v[0]}});
         chk({pin_power_o, pin_range_o}, {2{v[0]}});
      end
   endtask : t_polarity
   task automatic t_trigger;
      trig_req_i <= 1'b1;
      @(posedge aclk);
      trig_req_i <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(pin_trigger_o, 1'b1);
      repeat (505) @(posedge aclk);
      chk(pin_trigger_o, 1'b0);
      // negative trigger: idle high, active low
      wr(4'h0, 32'h0001_0102);
      repeat (2) @(posedge aclk);
      chk(pin_trigger_o, 1'b1);
      trig_req_i <= 1'b1;
      @(posedge aclk);
      trig_req_i <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(pin_trigger_o, 1'b0);
   endtask : t_trigger
   // reset, then each scenario in turn
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
      {close_mask, mem, st, step_code_i, active_func_i, trig_req_i, remote_active_i} = '0;
      {s_axi_wstrb, clr} = 5'h1F;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_disabled();
      t_enabled();
      t_recall();
      t_blocked();
      t_polarity();
      t_trigger();
      stop_test();
   end
   // hang guard
   initial begin
      repeat (5000) @(posedge aclk);
      miscompares++;
      stop_test();
   end
endmodule : ecp_port_test
